// *** rdc_pkg.sv ***
// package: register map, field layout, code tables and states of the redriver configuration block
package rdc_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] RDC_REG_GAIN_DRIVE = 8'h00;
	localparam logic [7:0] RDC_REG_PIN_EMU    = 8'h01;
	localparam logic [7:0] RDC_REG_RSVD_FIRST = 8'h02;
	localparam logic [7:0] RDC_REG_RSVD_LAST  = 8'h14;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RDC_GAIN_DRIVE_RST = 8'h06;
	localparam logic [7:0] RDC_PIN_EMU_RST    = 8'h0d;
	localparam logic [7:0] RDC_RSVD_RST       = 8'h00;
	localparam logic [3:0] RDC_GAIN_CODE_RST  = 4'h0;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int RDC_GAIN_BITS_LSB = 5;
	localparam int RDC_BAND_BIT      = 4;
	localparam int RDC_EMPH_LSB      = 2;
	localparam int RDC_SWING_LSB     = 0;
	localparam int RDC_EMU_GAIN_LSB  = 2;
	localparam int RDC_EMU_AUTO_LSB  = 0;

	// ----------------------------------------
	// swing and emphasis codes
	// ----------------------------------------
	localparam logic [1:0] RDC_SWING_400MV  = 2'h0;
	localparam logic [1:0] RDC_SWING_600MV  = 2'h1;
	localparam logic [1:0] RDC_SWING_1200MV = 2'h2;
	localparam logic [1:0] RDC_SWING_800MV  = 2'h3;
	localparam logic [1:0] RDC_EMPH_3P5DB   = 2'h0;
	localparam logic [1:0] RDC_EMPH_6DB     = 2'h1;
	localparam logic [1:0] RDC_EMPH_9DB     = 2'h2;
	localparam logic [1:0] RDC_EMPH_0DB     = 2'h3;

	// ----------------------------------------
	// gain codes: fixed levels and automatic tables, emphasis code n at bits 4n+3:4n
	// ----------------------------------------
	localparam logic [3:0]  RDC_GAIN_FIX_LOW  = 4'h0;
	localparam logic [3:0]  RDC_GAIN_FIX_MID  = 4'hc;
	localparam logic [3:0]  RDC_GAIN_FIX_HIGH = 4'hf;
	localparam logic [15:0] RDC_AUTO_MODE0    = 16'h037a;
	localparam logic [15:0] RDC_AUTO_MODE1    = 16'h37ad;
	localparam logic [15:0] RDC_AUTO_MODE2    = 16'h9bdf;

	// ----------------------------------------
	// serial target
	// ----------------------------------------
	localparam logic [6:0] RDC_SMB_ADDR_DEFAULT = 7'h2a;
	localparam logic [3:0] RDC_BITS_PER_BYTE    = 4'h8;

	typedef enum logic [1:0] {
		RDC_LOW  = 2'b00,
		RDC_MID  = 2'b01,
		RDC_HIGH = 2'b11
	} rdc_level_e;

	typedef enum logic [2:0] {
		RDC_SMB_IDLE  = 3'b000,
		RDC_SMB_ADDR  = 3'b001,
		RDC_SMB_ACK_A = 3'b010,
		RDC_SMB_RX    = 3'b011,
		RDC_SMB_ACK_W = 3'b100,
		RDC_SMB_TX    = 3'b101,
		RDC_SMB_MACK  = 3'b110
	} rdc_smb_state_e;

endpackage : rdc_pkg

// *** rdc_smb_target.sv ***
// module: serial management bus target giving byte access to the configuration registers
`timescale 1ns/100ps
module rdc_smb_target
	import rdc_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = RDC_SMB_ADDR_DEFAULT
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// register side
	output logic            wr_stb,
	output logic [7:0]      wr_data,
	output logic [7:0]      reg_ptr,
	input  wire logic [7:0] rd_data
);

	// ----------------------------------------
	// pin synchronisers, a change counts once stages two and three agree
	// ----------------------------------------
	logic [1:0] sy1, sy2, sy3, filt, filt_d;
	wire  [1:0] pin_raw = {scl_in, sda_in};

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sy1    <= 2'h3;
			sy2    <= 2'h3;
			sy3    <= 2'h3;
			filt   <= 2'h3;
			filt_d <= 2'h3;
		end else begin
			sy1    <= pin_raw;
			sy2    <= sy1;
			sy3    <= sy2;
			filt   <= (sy2 & ~(sy2 ^ sy3)) | (filt & (sy2 ^ sy3));
			filt_d <= filt;
		end
	end

	wire scl_f    = filt[1];
	wire sda_f    = filt[0];
	wire scl_rise = scl_f & ~filt_d[1];
	wire scl_fall = ~scl_f & filt_d[1];
	wire start_c  = scl_f & filt_d[1] & filt_d[0] & ~sda_f;
	wire stop_c   = scl_f & filt_d[1] & ~filt_d[0] & sda_f;

	// ----------------------------------------
	// byte engine
	// ----------------------------------------
	rdc_smb_state_e state;
	logic [3:0]     bit_cnt;
	logic [7:0]     shreg;
	logic           is_read;
	logic           ptr_loaded;
	wire            byte_end = scl_fall && (bit_cnt == RDC_BITS_PER_BYTE);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state      <= RDC_SMB_IDLE;
			bit_cnt    <= 4'h0;
			shreg      <= 8'h00;
			is_read    <= 1'b0;
			ptr_loaded <= 1'b0;
			reg_ptr    <= 8'h00;
			wr_stb     <= 1'b0;
			wr_data    <= 8'h00;
			sda_out    <= 1'b0;
			sda_oe     <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			if (start_c) begin
				state   <= RDC_SMB_ADDR;
				bit_cnt <= 4'h0;
				sda_oe  <= 1'b0;
			end else if (stop_c) begin
				state  <= RDC_SMB_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state)
				RDC_SMB_ADDR, RDC_SMB_RX: begin
					if (scl_rise) begin
						shreg   <= {shreg[6:0], sda_f};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_end) begin
						bit_cnt <= 4'h0;
						if (state == RDC_SMB_ADDR) begin
							// a foreign address leaves the bus alone until the next start
							state      <= (shreg[7:1] == TARGET_ADDR) ? RDC_SMB_ACK_A : RDC_SMB_IDLE;
							sda_oe     <= (shreg[7:1] == TARGET_ADDR);
							is_read    <= shreg[0];
							ptr_loaded <= 1'b0;
						end else begin
							state   <= RDC_SMB_ACK_W;
							sda_oe  <= 1'b1;
							wr_data <= shreg;
							if (ptr_loaded) begin
								wr_stb <= 1'b1;
							end else begin
								reg_ptr    <= shreg;
								ptr_loaded <= 1'b1;
							end
						end
					end
				end
				RDC_SMB_ACK_A: begin
					if (scl_fall) begin
						state  <= is_read ? RDC_SMB_TX : RDC_SMB_RX;
						shreg  <= rd_data;
						sda_oe <= is_read & ~rd_data[7];
					end
				end
				RDC_SMB_ACK_W: begin
					if (scl_fall) begin
						state  <= RDC_SMB_RX;
						sda_oe <= 1'b0;
						if (wr_stb || !ptr_loaded) begin
							reg_ptr <= reg_ptr;
						end
					end
					if (wr_stb) begin
						reg_ptr <= reg_ptr + 8'h01;
					end
				end
				RDC_SMB_TX: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_end) begin
						state   <= RDC_SMB_MACK;
						bit_cnt <= 4'h0;
						sda_oe  <= 1'b0;
					end else if (scl_fall) begin
						shreg  <= {shreg[6:0], 1'b0};
						sda_oe <= ~shreg[6];
					end
				end
				RDC_SMB_MACK: begin
					// a not-acknowledge from the host ends the read burst
					if (scl_rise) begin
						state   <= sda_f ? RDC_SMB_IDLE : RDC_SMB_MACK;
						reg_ptr <= reg_ptr + 8'h01;
					end else if (scl_fall) begin
						state  <= RDC_SMB_TX;
						shreg  <= rd_data;
						sda_oe <= ~rd_data[7];
					end
				end
				default: begin
					state <= RDC_SMB_IDLE;
				end
				endcase
			end
		end
	end

endmodule : rdc_smb_target

// *** rdc_config.sv ***
// module: equaliser gain, output swing and pre-emphasis selection with its register bank
// Behaviour
// - gain code is band bit over gain bits two to zero; reg0 bits 4 and 7:5.
// - reg0 bits 3:2 hold emphasis code, bits 1:0 hold swing code.
// - reg0 steers outputs only while setting source is low; reg0 resets to 06h.
// - reg1 bits 3:2 emulate gain level pin: 00 low, 01 middle, 11 high.
// - reg1 bits 1:0 emulate automatic gain select: 00 low, 01 middle, 11 high.
// - reg1 resets to 0Dh, selecting gain level high and automatic gain middle.
// - automatic mode 0 maps emphasis 00..11 to gains 1010, 0111, 0011, 0000.
// - automatic mode 1 maps emphasis 00..11 to gains 1101, 1010, 0111, 0011.
// - automatic mode 2 maps emphasis 00..11 to gains 1111, 1101, 1011, 1001.
// - automatic gain off: gain level low 0000, middle 1100, high 1111.
// - automatic and source both middle: gain taken from swing and emphasis pins.
// - swing code 00 400mV, 01 600mV, 10 1200mV, 11 800mV.
// - emphasis code 00 3.5dB, 01 6dB, 10 9dB, 11 0dB.
// - source middle: swing follows listener in DP mode, 800mV in TMDS mode.
// - source middle: emphasis follows listener in DP mode, 0dB in TMDS mode.
// - host reads and writes registers; writes are dropped while the listener owns them.
// - in TMDS mode the host sets gain through the register-1 pin emulation.
// - gain level pin is three-level and rests at middle when undriven.
`timescale 1ns/100ps
module rdc_config
	import rdc_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = RDC_SMB_ADDR_DEFAULT
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// three-level straps, 00 low, 01 middle, 11 high
	input  wire logic [1:0] setting_source_pin,
	input  wire logic [1:0] gain_level_pin,
	input  wire logic [1:0] automatic_gain_select,
	// two-level straps
	input  wire logic       swing_pin_lsb,
	input  wire logic       swing_pin_msb,
	input  wire logic       emphasis_pin_lsb,
	input  wire logic       emphasis_pin_msb,
	input  wire logic       sink_cable_detect,
	// link-training listener, same clock
	input  wire logic       listener_owns,
	input  wire logic [1:0] listener_swing,
	input  wire logic [1:0] listener_emphasis,
	// serial management bus
	input  wire logic       smb_scl,
	input  wire logic       smb_sda_in,
	output logic            smb_sda_out,
	output logic            smb_sda_oe,
	// datapath settings
	output logic [3:0]      gain_code,
	output logic [1:0]      swing_code,
	output logic [1:0]      emphasis_code
);

	// ----------------------------------------
	// strap synchronisers
	// ----------------------------------------
	localparam int NPIN = 11;

	// undriven gain level pin rests at middle, so its stages reset to middle
	localparam logic [NPIN-1:0] PIN_RST = 11'h080;

	logic [NPIN-1:0] ps1, ps2, ps3, pf;
	wire  [NPIN-1:0] pin_raw = {setting_source_pin, gain_level_pin, automatic_gain_select,
		swing_pin_msb, swing_pin_lsb, emphasis_pin_msb, emphasis_pin_lsb, sink_cable_detect};

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ps1 <= PIN_RST;
			ps2 <= PIN_RST;
			ps3 <= PIN_RST;
			pf  <= PIN_RST;
		end else begin
			ps1 <= pin_raw;
			ps2 <= ps1;
			ps3 <= ps2;
			pf  <= (ps2 & ~(ps2 ^ ps3)) | (pf & (ps2 ^ ps3));
		end
	end

	wire [1:0] src_pin_f   = pf[10:9];
	wire [1:0] gain_pin_f  = pf[8:7];
	wire [1:0] auto_pin_f  = pf[6:5];
	wire [1:0] swing_pin_f = pf[4:3];
	wire [1:0] emph_pin_f  = pf[2:1];
	wire       cable_f     = pf[0];

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	logic [7:0] gain_drive_select;
	logic [7:0] pin_level_emulation;
	logic [7:0] reserved_space [RDC_REG_RSVD_FIRST:RDC_REG_RSVD_LAST];
	logic       wr_stb;
	logic [7:0] wr_data;
	logic [7:0] reg_ptr;

	// the listener has the bank during training, so host writes then are lost, not queued
	wire wr_ok   = wr_stb & ~listener_owns;
	wire in_rsvd = (reg_ptr >= RDC_REG_RSVD_FIRST) && (reg_ptr <= RDC_REG_RSVD_LAST);
	wire [7:0] rd_data = (reg_ptr == RDC_REG_GAIN_DRIVE) ? gain_drive_select :
		(reg_ptr == RDC_REG_PIN_EMU) ? pin_level_emulation :
		in_rsvd ? reserved_space[reg_ptr] : 8'h00;

	rdc_smb_target #(
		.TARGET_ADDR (TARGET_ADDR)
	) u_smb (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.scl_in  (smb_scl),
		.sda_in  (smb_sda_in),
		.sda_out (smb_sda_out),
		.sda_oe  (smb_sda_oe),
		.wr_stb  (wr_stb),
		.wr_data (wr_data),
		.reg_ptr (reg_ptr),
		.rd_data (rd_data)
	);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			gain_drive_select   <= RDC_GAIN_DRIVE_RST;
			pin_level_emulation <= RDC_PIN_EMU_RST;
		end else if (wr_ok && reg_ptr == RDC_REG_GAIN_DRIVE) begin
			gain_drive_select <= wr_data;
		end else if (wr_ok && reg_ptr == RDC_REG_PIN_EMU) begin
			pin_level_emulation <= wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int i = RDC_REG_RSVD_FIRST; i <= RDC_REG_RSVD_LAST; i++) begin
			if (sys_rst) begin
				reserved_space[i] <= RDC_RSVD_RST;
			end else if (wr_ok && reg_ptr == 8'(i)) begin
				reserved_space[i] <= wr_data;
			end
		end
	end

	// ----------------------------------------
	// level decode and source selection
	// ----------------------------------------
	function automatic rdc_level_e rdc_lvl(input logic [1:0] c);
		rdc_level_e l;
		l = RDC_LOW;
		if (c == 2'h3) begin
			l = RDC_HIGH;
		end else if (c == 2'h1) begin
			l = RDC_MID;
		end
		return l;
	endfunction : rdc_lvl

	wire rdc_level_e src_lvl = rdc_lvl(src_pin_f);
	wire             reg_src = (src_lvl == RDC_LOW);
	// tmds lets the host steer gain through the emulated straps
	wire             use_emu = reg_src | cable_f;
	wire rdc_level_e gain_lvl = use_emu ?
		rdc_lvl(pin_level_emulation[RDC_EMU_GAIN_LSB +: 2]) : rdc_lvl(gain_pin_f);
	wire rdc_level_e auto_lvl = use_emu ?
		rdc_lvl(pin_level_emulation[RDC_EMU_AUTO_LSB +: 2]) : rdc_lvl(auto_pin_f);

	wire [1:0] next_swing_code = (src_lvl == RDC_LOW) ? gain_drive_select[RDC_SWING_LSB +: 2] :
		(src_lvl == RDC_HIGH) ? swing_pin_f :
		cable_f ? RDC_SWING_800MV : listener_swing;
	wire [1:0] next_emphasis_code = (src_lvl == RDC_LOW) ? gain_drive_select[RDC_EMPH_LSB +: 2] :
		(src_lvl == RDC_HIGH) ? emph_pin_f :
		cable_f ? RDC_EMPH_0DB : listener_emphasis;

	// ----------------------------------------
	// gain selection
	// ----------------------------------------
	wire [15:0] auto_table = (gain_lvl == RDC_LOW) ? RDC_AUTO_MODE0 :
		(gain_lvl == RDC_MID) ? RDC_AUTO_MODE1 : RDC_AUTO_MODE2;
	wire [3:0]  auto_gain  = auto_table[{next_emphasis_code, 2'b00} +: 4];
	wire [3:0]  fixed_gain = (gain_lvl == RDC_LOW) ? RDC_GAIN_FIX_LOW :
		(gain_lvl == RDC_MID) ? RDC_GAIN_FIX_MID : RDC_GAIN_FIX_HIGH;
	wire [3:0]  pin_gain   = {swing_pin_f[0], emph_pin_f[1], emph_pin_f[0], swing_pin_f[1]};
	wire [3:0]  reg_gain   = {gain_drive_select[RDC_BAND_BIT],
		gain_drive_select[RDC_GAIN_BITS_LSB +: 3]};
	wire [3:0]  next_gain_code = (auto_lvl == RDC_LOW) ? fixed_gain :
		(auto_lvl == RDC_HIGH) ? auto_gain :
		reg_src ? reg_gain : pin_gain;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			gain_code     <= RDC_GAIN_CODE_RST;
			swing_code    <= RDC_SWING_1200MV;
			emphasis_code <= RDC_EMPH_6DB;
		end else begin
			gain_code     <= next_gain_code;
			swing_code    <= next_swing_code;
			emphasis_code <= next_emphasis_code;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_reg0_write;
		wr_stb && !listener_owns && reg_ptr == RDC_REG_GAIN_DRIVE;
	endsequence

	sequence s_tmds_mid;
		src_lvl == RDC_MID && cable_f;
	endsequence

	property p_reset_values;
		@(posedge sys_clk) $fell(sys_rst) |-> gain_drive_select == 8'h06 && pin_level_emulation == 8'h0d;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("register reset value wrong");

	property p_reg0_write;
		@(posedge sys_clk) disable iff (sys_rst) s_reg0_write |=> gain_drive_select == $past(wr_data);
	endproperty
	a_reg0_write: assert property (p_reg0_write) else $error("register 0 write lost");

	property p_owned_no_write;
		@(posedge sys_clk) disable iff (sys_rst)
			wr_stb && listener_owns |=> $stable(gain_drive_select) && $stable(pin_level_emulation);
	endproperty
	a_owned_no_write: assert property (p_owned_no_write) else $error("write taken while listener owns");

	property p_reg_swing;
		@(posedge sys_clk) disable iff (sys_rst)
			src_lvl == RDC_LOW ##1 src_lvl == RDC_LOW |-> swing_code == $past(gain_drive_select[1:0]);
	endproperty
	a_reg_swing: assert property (p_reg_swing) else $error("register swing not applied");

	property p_pin_emph;
		@(posedge sys_clk) disable iff (sys_rst) src_lvl == RDC_HIGH |=> emphasis_code == $past(emph_pin_f);
	endproperty
	a_pin_emph: assert property (p_pin_emph) else $error("pin emphasis not applied");

	property p_tmds_fixed;
		@(posedge sys_clk) disable iff (sys_rst) s_tmds_mid |=> swing_code == 2'h3 && emphasis_code == 2'h3;
	endproperty
	a_tmds_fixed: assert property (p_tmds_fixed) else $error("tmds swing or emphasis wrong");

	property p_dp_follow;
		@(posedge sys_clk) disable iff (sys_rst)
			src_lvl == RDC_MID && !cable_f |=> swing_code == $past(listener_swing);
	endproperty
	a_dp_follow: assert property (p_dp_follow) else $error("listener swing not followed");

	property p_fixed_mid;
		@(posedge sys_clk) disable iff (sys_rst) auto_lvl == RDC_LOW && gain_lvl == RDC_MID |=> gain_code == 4'hc;
	endproperty
	a_fixed_mid: assert property (p_fixed_mid) else $error("fixed middle gain wrong");

	property p_auto1_lookup;
		@(posedge sys_clk) disable iff (sys_rst)
			auto_lvl == RDC_HIGH && gain_lvl == RDC_MID && next_emphasis_code == 2'h0 |=> gain_code == 4'hd;
	endproperty
	a_auto1_lookup: assert property (p_auto1_lookup) else $error("automatic mode 1 gain wrong");

	property p_pin_gain;
		@(posedge sys_clk) disable iff (sys_rst) auto_lvl == RDC_MID && src_lvl == RDC_MID |=>
			gain_code == {$past(swing_pin_f[0]), $past(emph_pin_f), $past(swing_pin_f[1])};
	endproperty
	a_pin_gain: assert property (p_pin_gain) else $error("pin gain mapping wrong");

	property p_unused_low;
		@(posedge sys_clk) disable iff (sys_rst)
			use_emu && pin_level_emulation[3:2] == 2'h2 |-> gain_lvl == RDC_LOW;
	endproperty
	a_unused_low: assert property (p_unused_low) else $error("encoding 10 not low");

	property p_gain_pin_rest;
		@(posedge sys_clk) $fell(sys_rst) |-> gain_pin_f == 2'h1;
	endproperty
	a_gain_pin_rest: assert property (p_gain_pin_rest) else $error("gain level pin not resting at middle");

	property p_reg_emph;
		@(posedge sys_clk) disable iff (sys_rst) src_lvl == RDC_LOW |=> emphasis_code == $past(gain_drive_select[3:2]);
	endproperty
	a_reg_emph: assert property (p_reg_emph) else $error("register emphasis not applied");

	property p_reg_gain;
		@(posedge sys_clk) disable iff (sys_rst) auto_lvl == RDC_MID && reg_src |=>
			gain_code == {$past(gain_drive_select[4]), $past(gain_drive_select[7:5])};
	endproperty
	a_reg_gain: assert property (p_reg_gain) else $error("register gain field wrong");

	property p_auto0_lookup;
		@(posedge sys_clk) disable iff (sys_rst)
			auto_lvl == RDC_HIGH && gain_lvl == RDC_LOW && next_emphasis_code == 2'h1 |=> gain_code == 4'h7;
	endproperty
	a_auto0_lookup: assert property (p_auto0_lookup) else $error("automatic mode 0 gain wrong");

	property p_auto2_lookup;
		@(posedge sys_clk) disable iff (sys_rst)
			auto_lvl == RDC_HIGH && gain_lvl == RDC_HIGH && next_emphasis_code == 2'h3 |=> gain_code == 4'h9;
	endproperty
	a_auto2_lookup: assert property (p_auto2_lookup) else $error("automatic mode 2 gain wrong");

	property p_fixed_high;
		@(posedge sys_clk) disable iff (sys_rst) auto_lvl == RDC_LOW && gain_lvl == RDC_HIGH |=> gain_code == 4'hf;
	endproperty
	a_fixed_high: assert property (p_fixed_high) else $error("fixed high gain wrong");

	property p_tmds_emu;
		@(posedge sys_clk) disable iff (sys_rst)
			cable_f && pin_level_emulation[1:0] == 2'h0 |-> auto_lvl == RDC_LOW;
	endproperty
	a_tmds_emu: assert property (p_tmds_emu) else $error("tmds emulation not used");

	property p_emu_mid;
		@(posedge sys_clk) disable iff (sys_rst)
			use_emu && pin_level_emulation[3:2] == 2'h1 |-> gain_lvl == RDC_MID;
	endproperty
	a_emu_mid: assert property (p_emu_mid) else $error("emulated middle level wrong");

	property p_listener_emph;
		@(posedge sys_clk) disable iff (sys_rst)
			src_lvl == RDC_MID && !cable_f |=> emphasis_code == $past(listener_emphasis);
	endproperty
	a_listener_emph: assert property (p_listener_emph) else $error("listener emphasis not followed");

endmodule : rdc_config

// *** rdc_host_model.sv ***
// serial management bus host model that drives the bus clock and pulls the data line
`timescale 1ns/100ps
module rdc_host_model
	import rdc_pkg::*;
#(
	parameter logic [6:0] ADDR = RDC_SMB_ADDR_DEFAULT
) (
	// clock
	input  wire logic sys_clk,
	// bus
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	// ----------------------------------------
	// bit level
	// ----------------------------------------
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : hold

	// phases of 8 clocks leave margin over the 4-edge pin filter
	task automatic xfer(input logic b, output logic r);
		sda_pull = ~b;
		hold(4);
		scl = 1'b1;
		hold(7);
		r = sda;
		hold(1);
		scl = 1'b0;
		hold(4);
	endtask : xfer

	// also serves as repeated start
	task automatic start();
		sda_pull = 1'b0;
		hold(4);
		scl = 1'b1;
		hold(8);
		sda_pull = 1'b1;
		hold(8);
		scl = 1'b0;
		hold(4);
	endtask : start

	// released data line rises through the pull-up
	task automatic stop();
		sda_pull = 1'b1;
		hold(4);
		scl = 1'b1;
		hold(8);
		sda_pull = 1'b0;
		hold(8);
	endtask : stop

	// ----------------------------------------
	// byte level
	// ----------------------------------------
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer(d[i], r);
		end
		xfer(1'b1, r);
		ack = ~r;
	endtask : put_byte

	// single-byte reads only, so the host always answers with a nack
	task automatic get_byte(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer(1'b1, d[i]);
		end
		xfer(1'b1, r);
	endtask : get_byte

	// ----------------------------------------
	// transactions
	// ----------------------------------------
	task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic k0, k1, k2;
		start();
		put_byte({a, 1'b0}, k0);
		put_byte(p, k1);
		put_byte(d, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
		logic k;
		start();
		put_byte({ADDR, 1'b0}, k);
		put_byte(p, k);
		start();
		put_byte({ADDR, 1'b1}, k);
		get_byte(d);
		stop();
	endtask : read_reg
endmodule : rdc_host_model

// *** testbench.sv ***
// self-checking bench for the redriver configuration block
`timescale 1ns/100ps
module testbench
	import rdc_pkg::*;
;
	logic       sys_clk, sys_rst, sl, sm, el, em, cad, lown;
	logic [1:0] src, gl, ag, lsw, lem;
	wire        scl, pull, sda_out, sda_oe;
	wire  [3:0] gain;
	wire  [1:0] swing, emph;
	wire        sda = ~(pull | (sda_oe & ~sda_out));
	int         failures, checks;
	logic [15:0] tbl [3] = '{16'h037a, 16'h37ad, 16'h9bdf};
	logic [1:0]  lv [3]  = '{2'h0, 2'h1, 2'h3};
	logic [15:0] fx      = 16'hf0c0;

	// ----------------------------------------
	// design and bus host
	// ----------------------------------------
	rdc_config #(.TARGET_ADDR(RDC_SMB_ADDR_DEFAULT)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.setting_source_pin(src), .gain_level_pin(gl), .automatic_gain_select(ag),
		.swing_pin_lsb(sl), .swing_pin_msb(sm), .emphasis_pin_lsb(el), .emphasis_pin_msb(em),
		.sink_cable_detect(cad), .listener_owns(lown), .listener_swing(lsw), .listener_emphasis(lem),
		.smb_scl(scl), .smb_sda_in(sda), .smb_sda_out(sda_out), .smb_sda_oe(sda_oe),
		.gain_code(gain), .swing_code(swing), .emphasis_code(emph));
	rdc_host_model #(.ADDR(RDC_SMB_ADDR_DEFAULT)) host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(pull));

	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic ok;
		host.write_reg(RDC_SMB_ADDR_DEFAULT, p, d, ok);
		check("ack", 8'h01, {7'h0, ok});
	endtask : wr

	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		logic [7:0] d;
		host.read_reg(p, d);
		check("read", e, d);
	endtask : rd

	// pin filter plus output register take five edges
	task automatic outs(input logic [7:0] e);
		repeat (6) @(negedge sys_clk);
		check("gain swing emphasis", e, {gain, swing, emph});
	endtask : outs

	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		logic ok;
		failures = 0;
		checks = 0;
		sys_rst = 1'b1;
		src = 2'h0;
		gl = 2'h1;
		ag = 2'h0;
		{sl, sm, el, em, cad, lown} = 6'h00;
		lsw = 2'h0;
		lem = 2'h0;
		repeat (10) @(negedge sys_clk);
		sys_rst = 1'b0;
		outs(8'h09);
		rd(8'h00, 8'h06);
		rd(8'h01, 8'h0d);
		rd(8'h14, 8'h00);
		wr(8'h10, 8'h5a);
		rd(8'h10, 8'h5a);
		wr(8'h15, 8'h77);
		rd(8'h15, 8'h00);
		wr(8'h00, 8'h9b);
		outs(8'hce);
		rd(8'h00, 8'h9b);
		// automatic lookup per mode and emphasis code
		for (int m = 0; m < 3; m++) begin
			wr(8'h01, {4'h0, lv[m], 2'h3});
			for (int e = 0; e < 4; e++) begin
				wr(8'h00, {4'h0, e[1:0], 2'h2});
				outs({tbl[m][4*e +: 4], 2'h2, e[1:0]});
			end
		end
		// fixed gain, encoding 10 included
		for (int k = 0; k < 4; k++) begin
			wr(8'h01, {4'h0, k[1:0], 2'h0});
			outs({fx[4*k +: 4], 4'hb});
		end
		wr(8'h01, 8'h0e);
		outs(8'hfb);
		lown = 1'b1;
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h0e);
		lown = 1'b0;
		wr(8'h01, 8'h0d);
		// pin source, listener and cable modes
		src = 2'h1;
		ag = 2'h1;
		{sl, sm, el, em} = 4'b1001;
		lsw = 2'h1;
		lem = 2'h2;
		outs(8'hc6);
		cad = 1'b1;
		outs(8'hcf);
		wr(8'h01, 8'h0c);
		outs(8'hff);
		cad = 1'b0;
		src = 2'h3;
		ag = 2'h0;
		gl = 2'h3;
		outs(8'hf6);
		wr(8'h00, 8'h33);
		outs(8'hf6);
		host.write_reg(7'h11, 8'h00, 8'h00, ok);
		check("foreign ack", 8'h00, {7'h0, ok});
		stop_test();
	end

	// a hung bus transfer ends the run here
	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		$display("mismatch run length expected finished seen running");
		stop_test();
	end
endmodule : testbench
